// ---- hdl/operand_decoder_defines.svh ----
// Purpose: Named codes, masks and widths of the operand decoder
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef OPERAND_DECODER_DEFINES_SVH
`define OPERAND_DECODER_DEFINES_SVH

// ---------------------------------------------------------------
// Field widths
// ---------------------------------------------------------------
`define OPD_CODE_W 6
`define OPD_BYTE_W 8

// ---------------------------------------------------------------
// Special-register legality masks, bit n is code n
// ---------------------------------------------------------------
`define OPD_SR_MASK 64'h0000_0100_0D9F_3FEF
`define OPD_SR1_MASK 64'h0000_000F_0200_2BEF
`define OPD_SR2_MASK 64'h0000_0000_0000_2BEF
`define OPD_SR_PORT_A 6'h00
`define OPD_SR_RECV 6'h19

// ---------------------------------------------------------------
// Pair, addressing and flag legality
// ---------------------------------------------------------------
`define OPD_PAIR_MASK 8'h1F
`define OPD_PAIR_SP 3'h0
`define OPD_RPA_MASK 16'h00FF
`define OPD_FULL_MASK 16'hF8FE
`define OPD_WORD_MASK 16'hF83C
`define OPD_RPA_NONE 4'h0
`define OPD_IRF_COUNT 6'h12

// ---------------------------------------------------------------
// Decoded addressing fields
// ---------------------------------------------------------------
`define OPD_BASE_NONE 2'h0
`define OPD_BASE_BC 2'h1
`define OPD_BASE_DE 2'h2
`define OPD_BASE_HL 2'h3
`define OPD_STEP_NONE 2'h0
`define OPD_STEP_INC 2'h1
`define OPD_STEP_DEC 2'h2
`define OPD_STEP_INC2 2'h3
`define OPD_IDX_NONE 3'h0
`define OPD_IDX_A 3'h1
`define OPD_IDX_B 3'h2
`define OPD_IDX_EA 3'h3
`define OPD_IDX_BYTE 3'h4

`endif

// ---- hdl/operand_decoder_pkg.sv ----
// Purpose: Types of the operand decoder
// Assumes: Nothing
// Notes: Operand group selector
package operand_decoder_pkg;
  typedef enum logic [3:0] {
    OP_GPR = 4'h0,
    OP_ALT = 4'h1,
    OP_SR = 4'h2,
    OP_SR1 = 4'h3,
    OP_SR2 = 4'h4,
    OP_PAIR = 4'h5,
    OP_RPA = 4'h6,
    OP_FULL_IND = 4'h7,
    OP_WORD_IND = 4'h8,
    OP_WORK = 4'h9,
    OP_IRF = 4'hA
  } op_kind_t;
endpackage

// ---- hdl/operand_field_decoder.sv ----
// Purpose: Decodes operand fields into register selections
// Assumes: Operand fields come from logic on ref_clk
// Notes: One cycle latency, illegal codes select nothing
`include "operand_decoder_defines.svh"

// Function
// - General field picks one of eight registers
// - Alternate field: accumulator halves then B to L
// - Primary special group excludes receive buffer
// - Second group adds receive buffer, converter results
// - Third group limited to ports, masks, modes
// - Full indirect: plain, step, indexed modes
// - Word indirect: no BC, double increment
// - Working offset is low address byte
// - Interrupt operand selects every listed flag
// - Six-bit special code, zero is port A
// - Three-bit pair code, zero is stack pointer
// - Four-bit indirect code, zero is none
module operand_field_decoder (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic opValid,
  input wire operand_decoder_pkg::op_kind_t opKind,
  input wire logic [5:0] opCode,
  input wire logic [7:0] immByte,
  input wire logic [7:0] workHigh,
  output logic resValid,
  output logic resIllegal,
  output logic [5:0] resIndex,
  output logic [1:0] resBase,
  output logic [1:0] resStep,
  output logic [2:0] resIdx,
  output logic [15:0] resWorkAddr
);
  logic valid_reg, valid_next;
  logic illegal_reg, illegal_next;
  logic [5:0] index_reg, index_next;
  logic [1:0] base_reg, base_next;
  logic [1:0] step_reg, step_next;
  logic [2:0] idx_reg, idx_next;
  logic [15:0] addr_reg, addr_next;
  logic legal;
  logic [3:0] amode;
  sr_check_if srChk ();
  localparam logic [7:0] PAIR_LEGAL = `OPD_PAIR_MASK;
  localparam logic [15:0] RPA_LEGAL = `OPD_RPA_MASK;
  localparam logic [15:0] FULL_LEGAL = `OPD_FULL_MASK;
  localparam logic [15:0] WORD_LEGAL = `OPD_WORD_MASK;

  // -------------------------------------------------------------
  // Special-register group check
  // -------------------------------------------------------------
  sr_group_check srCheck (
    .chk(srChk.judge)
  );

  always_comb begin
    case (opKind)
      operand_decoder_pkg::OP_SR1: srChk.group = 2'h1;
      operand_decoder_pkg::OP_SR2: srChk.group = 2'h2;
      default: srChk.group = 2'h0;
    endcase
    srChk.code = opCode;
  end

  // -------------------------------------------------------------
  // Next-value decode
  // -------------------------------------------------------------
  assign amode = opCode[3:0];

  always_comb begin
    legal = 1'b0;
    index_next = 6'h00;
    base_next = `OPD_BASE_NONE;
    step_next = `OPD_STEP_NONE;
    idx_next = `OPD_IDX_NONE;
    addr_next = 16'h0000;
    case (opKind)
      operand_decoder_pkg::OP_GPR, operand_decoder_pkg::OP_ALT: begin
        legal = (opCode[5:3] == 3'h0);
      end
      operand_decoder_pkg::OP_SR, operand_decoder_pkg::OP_SR1,
      operand_decoder_pkg::OP_SR2: begin
        legal = srChk.legal;
      end
      operand_decoder_pkg::OP_PAIR: begin
        legal = (opCode[5:3] == 3'h0) && PAIR_LEGAL[opCode[2:0]];
      end
      operand_decoder_pkg::OP_RPA: begin
        legal = (opCode[5:4] == 2'h0) && RPA_LEGAL[amode];
      end
      operand_decoder_pkg::OP_FULL_IND: begin
        legal = (opCode[5:4] == 2'h0) && FULL_LEGAL[amode];
      end
      operand_decoder_pkg::OP_WORD_IND: begin
        legal = (opCode[5:4] == 2'h0) && WORD_LEGAL[amode];
      end
      operand_decoder_pkg::OP_WORK: begin
        legal = 1'b1;
        addr_next = {workHigh, immByte};
      end
      operand_decoder_pkg::OP_IRF: begin
        legal = (opCode < `OPD_IRF_COUNT);
      end
      default: legal = 1'b0;
    endcase
    if (legal && (opKind inside {operand_decoder_pkg::OP_RPA,
        operand_decoder_pkg::OP_FULL_IND, operand_decoder_pkg::OP_WORD_IND})) begin
      case (amode)
        4'h1: base_next = `OPD_BASE_BC;
        4'h2, 4'h4, 4'h6, 4'hB: base_next = `OPD_BASE_DE;
        4'h0: base_next = `OPD_BASE_NONE;
        default: base_next = `OPD_BASE_HL;
      endcase
      case (amode)
        4'h4, 4'h5: begin
          if (opKind == operand_decoder_pkg::OP_WORD_IND) begin
            step_next = `OPD_STEP_INC2;
          end else begin
            step_next = `OPD_STEP_INC;
          end
        end
        4'h6, 4'h7: step_next = `OPD_STEP_DEC;
        default: step_next = `OPD_STEP_NONE;
      endcase
      case (amode)
        4'hB, 4'hF: idx_next = `OPD_IDX_BYTE;
        4'hC: idx_next = `OPD_IDX_A;
        4'hD: idx_next = `OPD_IDX_B;
        4'hE: idx_next = `OPD_IDX_EA;
        default: idx_next = `OPD_IDX_NONE;
      endcase
    end
    if (legal && (opKind != operand_decoder_pkg::OP_WORK)) begin
      index_next = opCode;
    end
    valid_next = opValid;
    illegal_next = opValid && !legal;
    if (!opValid || !legal) begin
      index_next = 6'h00;
      base_next = `OPD_BASE_NONE;
      step_next = `OPD_STEP_NONE;
      idx_next = `OPD_IDX_NONE;
      addr_next = 16'h0000;
    end
  end

  // -------------------------------------------------------------
  // Result registers
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_reg <= 1'b0;
      illegal_reg <= 1'b0;
      index_reg <= 6'h00;
      base_reg <= 2'h0;
      step_reg <= 2'h0;
      idx_reg <= 3'h0;
      addr_reg <= 16'h0000;
    end else begin
      valid_reg <= valid_next;
      illegal_reg <= illegal_next;
      index_reg <= index_next;
      base_reg <= base_next;
      step_reg <= step_next;
      idx_reg <= idx_next;
      addr_reg <= addr_next;
    end
  end

  assign resValid = valid_reg;
  assign resIllegal = illegal_reg;
  assign resIndex = index_reg;
  assign resBase = base_reg;
  assign resStep = step_reg;
  assign resIdx = idx_reg;
  assign resWorkAddr = addr_reg;

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence sTake(operand_decoder_pkg::op_kind_t k, logic [5:0] c);
    opValid && (opKind == k) && (opCode == c);
  endsequence

  sequence sGood(logic [5:0] c);
    resValid && !resIllegal && (resIndex == c);
  endsequence

  a_gpr_select: assert property (
    (opValid && opKind == operand_decoder_pkg::OP_GPR && opCode[5:3] == 3'h0)
    |=> resValid && !resIllegal && resIndex == $past(opCode))
    else $error("general register not selected");

  a_alt_select: assert property (
    sTake(operand_decoder_pkg::OP_ALT, 6'h07) |=> sGood(6'h07))
    else $error("alternate register not selected");

  a_sr_no_recv: assert property (
    sTake(operand_decoder_pkg::OP_SR, `OPD_SR_RECV) |=> resIllegal && resIndex == 6'h00)
    else $error("receive buffer accepted in primary group");

  a_sr1_recv: assert property (
    sTake(operand_decoder_pkg::OP_SR1, `OPD_SR_RECV) |=> sGood(`OPD_SR_RECV))
    else $error("receive buffer refused in second group");

  a_sr2_limit: assert property (
    sTake(operand_decoder_pkg::OP_SR2, 6'h0C) |=> resIllegal)
    else $error("third group accepted excluded register");

  a_full_index: assert property (
    sTake(operand_decoder_pkg::OP_FULL_IND, 6'h0C)
    |=> resBase == `OPD_BASE_HL && resIdx == `OPD_IDX_A && !resIllegal)
    else $error("indexed mode misdecoded");

  a_word_no_bc: assert property (
    sTake(operand_decoder_pkg::OP_WORD_IND, 6'h01)
    |=> resIllegal && resIndex == 6'h00 && resBase == `OPD_BASE_NONE)
    else $error("word indirect accepted pair BC");

  a_word_step: assert property (
    sTake(operand_decoder_pkg::OP_WORD_IND, 6'h05)
    |=> resStep == `OPD_STEP_INC2 && resBase == `OPD_BASE_HL)
    else $error("double increment missing");

  a_work_address: assert property (
    (opValid && opKind == operand_decoder_pkg::OP_WORK)
    |=> resWorkAddr == {$past(workHigh), $past(immByte)})
    else $error("working address wrong");

  a_irf_range: assert property (
    (opValid && opKind == operand_decoder_pkg::OP_IRF)
    |=> resIllegal == ($past(opCode) >= `OPD_IRF_COUNT))
    else $error("interrupt flag range wrong");

  a_sr_port_a: assert property (
    sTake(operand_decoder_pkg::OP_SR, `OPD_SR_PORT_A) |=> sGood(`OPD_SR_PORT_A))
    else $error("port A not selected");

  a_pair_range: assert property (
    (opValid && opKind == operand_decoder_pkg::OP_PAIR)
    |=> resIllegal == ($past(opCode) > 6'h04))
    else $error("pair code range wrong");

  a_rpa_none: assert property (
    sTake(operand_decoder_pkg::OP_RPA, 6'h00)
    |=> !resIllegal && resBase == `OPD_BASE_NONE)
    else $error("no-pair code misdecoded");

  a_illegal_blank: assert property (
    resIllegal |-> resValid && resIndex == 6'h00 && resBase == `OPD_BASE_NONE
      && resWorkAddr == 16'h0000)
    else $error("illegal code selected something");
endmodule // operand_field_decoder

// ---- hdl/sr_check_if.sv ----
// Purpose: Carries a special-register code to its legality check
// Assumes: Same clock on both sides
// Notes: Purely combinational
interface sr_check_if;
  logic [1:0] group;
  logic [5:0] code;
  logic legal;
  modport requester (output group, output code, input legal);
  modport judge (input group, input code, output legal);
endinterface

// ---- hdl/sr_group_check.sv ----
// Purpose: Legality of a special-register code per group
// Assumes: group 0 primary, 1 second, 2 third
// Notes: Combinational lookup
`include "operand_decoder_defines.svh"

module sr_group_check (
  sr_check_if.judge chk
);
  logic [63:0] mask;

  always_comb begin
    case (chk.group)
      2'h0: mask = `OPD_SR_MASK;
      2'h1: mask = `OPD_SR1_MASK;
      2'h2: mask = `OPD_SR2_MASK;
      default: mask = 64'h0;
    endcase
    chk.legal = mask[chk.code];
  end
endmodule // sr_group_check

// ---- tb/regfile_model.sv ----
// Purpose: Far-side model counting selections taken
// Assumes: Results registered on ref_clk
// Notes: Illegal results are not taken
module regfile_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic resValid,
  input wire logic resIllegal,
  output logic [15:0] takenCount
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] taken_reg;
  logic [15:0] taken_next;
  always_comb begin
    taken_next = taken_reg + {15'h0000, resValid & ~resIllegal};
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      taken_reg <= 16'h0000;
    end else begin
      taken_reg <= taken_next;
    end
  end
  assign takenCount = taken_reg;
endmodule // regfile_model

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench of the operand decoder
// Assumes: Inputs driven on the falling edge
// Notes: Sweeps every code of every group except working, which sweeps every offset byte with code zero
`include "operand_decoder_defines.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic opValid = 1'b0;
  operand_decoder_pkg::op_kind_t opKind = operand_decoder_pkg::OP_GPR;
  logic [5:0] opCode = 6'h00;
  logic [7:0] immByte = 8'h00;
  logic [7:0] workHigh = 8'h00;
  logic resValid;
  logic resIllegal;
  logic [5:0] resIndex;
  logic [1:0] resBase;
  logic [1:0] resStep;
  logic [2:0] resIdx;
  logic [15:0] resWorkAddr;
  logic [15:0] takenCount;
  logic [63:0] srMask = `OPD_SR_MASK;
  logic [63:0] sr1Mask = `OPD_SR1_MASK;
  logic [63:0] sr2Mask = `OPD_SR2_MASK;
  logic [30:0] seen;
  logic [30:0] want;
  int nFail = 0;
  int samplesChecked = 0;
  int nLegal = 0;
  wire logic [30:0] outs = {resWorkAddr, resValid, resIllegal, resIndex, resBase, resStep, resIdx};

  always #5 ref_clk = ~ref_clk;

  operand_field_decoder operand_field_decoder_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .opValid(opValid), .opKind(opKind), .opCode(opCode), .immByte(immByte),
    .workHigh(workHigh), .resValid(resValid), .resIllegal(resIllegal), .resIndex(resIndex),
    .resBase(resBase), .resStep(resStep), .resIdx(resIdx), .resWorkAddr(resWorkAddr));
  regfile_model regfile_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .resValid(resValid),
    .resIllegal(resIllegal), .takenCount(takenCount));

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  function automatic logic [30:0] expectOf(operand_decoder_pkg::op_kind_t k, logic [5:0] c,
      logic [7:0] imm, logic [7:0] hi);
    logic ok;
    logic [1:0] b;
    logic [1:0] s;
    logic [2:0] x;
    b = 2'h0;
    s = 2'h0;
    x = 3'h0;
    case (k)
      operand_decoder_pkg::OP_SR: ok = srMask[c];
      operand_decoder_pkg::OP_SR1: ok = sr1Mask[c];
      operand_decoder_pkg::OP_SR2: ok = sr2Mask[c];
      operand_decoder_pkg::OP_PAIR: ok = c < 6'h05;
      operand_decoder_pkg::OP_RPA: ok = c < 6'h08;
      operand_decoder_pkg::OP_FULL_IND: ok = c inside {[6'h01:6'h07], [6'h0B:6'h0F]};
      operand_decoder_pkg::OP_WORD_IND: ok = c inside {[6'h02:6'h05], [6'h0B:6'h0F]};
      operand_decoder_pkg::OP_WORK: return {hi, imm, 15'h4000};
      operand_decoder_pkg::OP_IRF: ok = c < 6'h12;
      default: ok = c < 6'h08;
    endcase
    if (!ok) return 31'h0000_6000;
    if (k inside {operand_decoder_pkg::OP_RPA, operand_decoder_pkg::OP_FULL_IND,
        operand_decoder_pkg::OP_WORD_IND}) begin
      b = (c == 6'h01) ? 2'h1 : (c inside {6'h02, 6'h04, 6'h06, 6'h0B}) ? 2'h2 :
        (c == 6'h00) ? 2'h0 : 2'h3;
      s = (c inside {6'h04, 6'h05}) ? ((k == operand_decoder_pkg::OP_WORD_IND) ? 2'h3 : 2'h1) :
        (c inside {6'h06, 6'h07}) ? 2'h2 : 2'h0;
      x = (c inside {6'h0B, 6'h0F}) ? 3'h4 : (c > 6'h0B) ? 3'(c - 6'h0B) : 3'h0;
    end
    return {16'h0000, 1'b1, 1'b0, c, b, s, x};
  endfunction

  task automatic op(operand_decoder_pkg::op_kind_t k, logic [5:0] c, logic [7:0] imm,
      logic [7:0] hi);
    opValid = 1'b1;
    opKind = k;
    opCode = c;
    immByte = imm;
    workHigh = hi;
    want = expectOf(k, c, imm, hi);
    nLegal += want[13] ? 0 : 1;
    @(negedge ref_clk);
    seen = outs;
  endtask

  task automatic check(logic [30:0] got, logic [30:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic scenRegisters();
    for (int c = 0; c < 64; c++) begin
      op(operand_decoder_pkg::OP_GPR, c[5:0], 8'h5A, 8'hA5);
      check(seen, want);
      op(operand_decoder_pkg::OP_ALT, c[5:0], 8'h5A, 8'hA5);
      check(seen, want);
    end
  endtask

  task automatic scenSpecial();
    for (int c = 0; c < 64; c++) begin
      op(operand_decoder_pkg::OP_SR, c[5:0], 8'h00, 8'h00);
      check(seen, want);
      op(operand_decoder_pkg::OP_SR1, c[5:0], 8'h00, 8'h00);
      check(seen, want);
      op(operand_decoder_pkg::OP_SR2, c[5:0], 8'h00, 8'h00);
      check(seen, want);
    end
    op(operand_decoder_pkg::OP_SR, 6'h00, 8'h00, 8'h00);
    check(seen, 31'h0000_4000);
    op(operand_decoder_pkg::OP_SR, 6'h19, 8'h00, 8'h00);
    check(seen, 31'h0000_6000);
    op(operand_decoder_pkg::OP_SR1, 6'h19, 8'h00, 8'h00);
    check(seen, 31'h0000_4C80);
    op(operand_decoder_pkg::OP_SR2, 6'h19, 8'h00, 8'h00);
    check(seen, 31'h0000_6000);
  endtask

  task automatic scenPairs();
    for (int c = 0; c < 64; c++) begin
      op(operand_decoder_pkg::OP_PAIR, c[5:0], 8'h00, 8'h00);
      check(seen, want);
    end
    op(operand_decoder_pkg::OP_PAIR, 6'h05, 8'h00, 8'h00);
    check(seen, 31'h0000_6000);
  endtask

  task automatic scenIndirect();
    for (int c = 0; c < 64; c++) begin
      op(operand_decoder_pkg::OP_RPA, c[5:0], 8'h00, 8'h00);
      check(seen, want);
      op(operand_decoder_pkg::OP_FULL_IND, c[5:0], 8'h00, 8'h00);
      check(seen, want);
      op(operand_decoder_pkg::OP_WORD_IND, c[5:0], 8'h00, 8'h00);
      check(seen, want);
    end
    op(operand_decoder_pkg::OP_RPA, 6'h01, 8'h00, 8'h00);
    check(seen, 31'h0000_40A0);
    op(operand_decoder_pkg::OP_FULL_IND, 6'h0C, 8'h00, 8'h00);
    check(seen, 31'h0000_4661);
    op(operand_decoder_pkg::OP_WORD_IND, 6'h04, 8'h00, 8'h00);
    check(seen, 31'h0000_4258);
    op(operand_decoder_pkg::OP_WORD_IND, 6'h01, 8'h00, 8'h00);
    check(seen, 31'h0000_6000);
  endtask

  task automatic scenWork();
    for (int v = 0; v < 256; v++) begin
      op(operand_decoder_pkg::OP_WORK, 6'h00, v[7:0], ~v[7:0]);
      check(seen, want);
    end
    op(operand_decoder_pkg::OP_WORK, 6'h00, 8'h34, 8'h12);
    check(seen, 31'h091A_4000);
    op(operand_decoder_pkg::OP_WORK, 6'h3F, 8'h34, 8'h12);
    check(seen, 31'h091A_4000);
  endtask

  task automatic scenFlags();
    for (int c = 0; c < 64; c++) begin
      op(operand_decoder_pkg::OP_IRF, c[5:0], 8'h00, 8'h00);
      check(seen, want);
    end
    op(operand_decoder_pkg::OP_IRF, 6'h11, 8'h00, 8'h00);
    check(seen, 31'h0000_4880);
  endtask

  task automatic scenIdleReset();
    opValid = 1'b0;
    @(negedge ref_clk);
    check(outs, 31'h0000_0000);
    check({15'h0000, takenCount}, 31'(nLegal));
    opValid = 1'b1;
    opCode = 6'h01;
    rst_n = 1'b0;
    @(posedge ref_clk);
    #1;
    check(outs, 31'h0000_0000);
    @(negedge ref_clk);
    rst_n = 1'b1;
    opValid = 1'b0;
    @(negedge ref_clk);
    check(outs, 31'h0000_0000);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    nFail++;
    closeOut();
  end

  initial begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    scenRegisters();
    scenSpecial();
    scenPairs();
    scenIndirect();
    scenWork();
    scenFlags();
    scenIdleReset();
    closeOut();
  end
endmodule // testbench
